// >>> uflt_pkg.sv
// Package with register map, field layout and types for the UART level and turn-around block.
`default_nettype none
package uflt_pkg;
  localparam logic [7:0] OFS_TX_LVL = 8'h00;
  localparam logic [7:0] OFS_RX_LVL = 8'h04;
  localparam logic [7:0] OFS_FLOW_HI = 8'h08;
  localparam logic [7:0] OFS_FLOW_LO = 8'h0c;
  localparam logic [7:0] OFS_PRESC = 8'h10;
  localparam logic [7:0] OFS_TURN = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] RST_LEVEL = 8'h00;
  localparam logic [3:0] RST_PRESC = 4'h0;
  localparam logic [7:0] LVL_MIN = 8'h01;
  localparam logic [7:0] LVL_MAX = 8'h80;
  localparam int CTRL_NINE = 0;
  localparam int CTRL_DTR_SEL = 3;
  localparam int CTRL_AUTO_RTS = 6;
  localparam int CTRL_FIFO128 = 7;
  localparam int IRQ_W = 4;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_FLOW = 2;
  localparam int IRQ_TURN = 3;
  typedef enum logic [1:0] {
    UFLT_IDLE = 2'b00,
    UFLT_TX = 2'b01,
    UFLT_COUNT = 2'b10
  } uflt_dir_e;
  typedef struct packed {
    logic [7:0] tx_fill;
    logic [7:0] rx_fill;
    logic tx_busy;
    logic bit_tick;
  } uflt_in_s;
endpackage
`default_nettype wire

// >>> uflt_core.sv
// Threshold registers, flow control and RS-485 turn-around logic with an APB slave.
//
// Register access over APB and the placing of the registers were decided locally.
`default_nettype none
//
// Behaviour
// - The transmit trigger level is an 8-bit register used for the transmit DMA request and interrupt, 1 to 128.
// - The receive trigger level is an 8-bit register used for the receive DMA request and interrupt, 1 to 128.
// - Codes 0x00 and 0x01 both mean level 1, 0x80 means 128, and codes between mean themselves.
// - The levels apply only while 128-entry FIFO mode is selected.
// - An 8-bit upper receive threshold tells flow control when the sender must stop.
// - An 8-bit lower receive threshold tells flow control when the sender may resume.
// - The same upper and lower thresholds serve hardware and software flow control.
// - The prescaler is four bits in the low nibble, reset to zero, with bits 7:4 reserved.
// - In 9-bit mode one modem output line controls the external driver direction.
// - After the last bit leaves the shift register the turn-around delay is loaded and counted down.
// - The delay counts whole bit periods and is eight bits wide.
// - When the count reaches zero the direction line goes low for reception.
// - 9-bit operation is entered only while its enable bit is set.
// - A select bit picks the request line when clear and the terminal-ready line when set.
// - Automatic request flow control raises the request line above the upper threshold and lowers it below the lower one; here it rises at the upper one too.
module uflt_core
  import uflt_pkg::*;
#(
  parameter int LVL_W = 8
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire uflt_in_s UART_IN,
  output logic TX_DMA_REQ,
  output logic RX_DMA_REQ,
  output logic REQUEST_LINE,
  output logic TERMINAL_READY_LINE,
  output logic SW_FLOW_STOP,
  output logic [3:0] PRESCALE,
  output logic IRQ
);

  function automatic logic [LVL_W-1:0] lvl_decode(input logic [7:0] code);
    if (code < LVL_MIN) begin
      lvl_decode = LVL_W'(LVL_MIN);
    end else if (code > LVL_MAX) begin
      lvl_decode = LVL_W'(LVL_MAX);
    end else begin
      lvl_decode = LVL_W'(code);
    end
  endfunction

  function automatic logic addr_hit(input logic en, input logic [7:0] addr,
                                    input logic [7:0] ofs);
    addr_hit = en && (addr == ofs);
  endfunction

  logic [7:0] tx_lvl_r;
  logic [7:0] rx_lvl_r;
  logic [7:0] flow_hi_r;
  logic [7:0] flow_lo_r;
  logic [3:0] presc_r;
  logic [7:0] turn_r;
  logic [7:0] ctrl_r;
  logic [7:0] cnt_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic flow_stop_r;
  logic tx_busy_d_r;
  logic dir_r;
  logic [31:0] rdata_r;
  uflt_dir_e st_r;
  uflt_dir_e st_nxt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic mode128;
  logic tx_trig;
  logic rx_trig;
  logic last_bit_out;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic [31:0] rdata_nxt;
  logic nine_on;
  logic count_done;
  logic cnt_load;
  logic cnt_step;
  logic [LVL_W-1:0] tx_level;
  logic [LVL_W-1:0] rx_level;
  logic [LVL_W-1:0] hi_level;
  logic [LVL_W-1:0] lo_level;

  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign mode128 = ctrl_r[CTRL_FIFO128];

  always_comb begin
    unique case (PADDR)
      OFS_TX_LVL,
      OFS_RX_LVL,
      OFS_FLOW_HI,
      OFS_FLOW_LO,
      OFS_PRESC,
      OFS_TURN,
      OFS_CTRL,
      OFS_STAT,
      OFS_IRQ_STAT,
      OFS_IRQ_MASK: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Decoded levels: codes below one read as one, codes above the top read as the top.
  assign tx_level = lvl_decode(tx_lvl_r);
  assign rx_level = lvl_decode(rx_lvl_r);
  assign hi_level = lvl_decode(flow_hi_r);
  assign lo_level = lvl_decode(flow_lo_r);

  // Trigger comparisons against the decoded levels.
  assign tx_trig = mode128 && (UART_IN.tx_fill < tx_level);
  assign rx_trig = mode128 && (UART_IN.rx_fill >= rx_level);
  assign TX_DMA_REQ = tx_trig;
  assign RX_DMA_REQ = rx_trig;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tx_lvl_r <= RST_LEVEL;
    end else if (addr_hit(wr_en, PADDR, OFS_TX_LVL)) begin
      tx_lvl_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rx_lvl_r <= RST_LEVEL;
    end else if (addr_hit(wr_en, PADDR, OFS_RX_LVL)) begin
      rx_lvl_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      flow_hi_r <= RST_LEVEL;
    end else if (addr_hit(wr_en, PADDR, OFS_FLOW_HI)) begin
      flow_hi_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      flow_lo_r <= RST_LEVEL;
    end else if (addr_hit(wr_en, PADDR, OFS_FLOW_LO)) begin
      flow_lo_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      presc_r <= RST_PRESC;
    end else if (addr_hit(wr_en, PADDR, OFS_PRESC)) begin
      presc_r <= PWDATA[3:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      turn_r <= RST_LEVEL;
    end else if (addr_hit(wr_en, PADDR, OFS_TURN)) begin
      turn_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= RST_LEVEL;
    end else if (addr_hit(wr_en, PADDR, OFS_CTRL)) begin
      ctrl_r <= PWDATA[7:0];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_mask_r <= '0;
    end else if (addr_hit(wr_en, PADDR, OFS_IRQ_MASK)) begin
      irq_mask_r <= PWDATA[IRQ_W-1:0];
    end
  end

  assign PRESCALE = presc_r;

  // One flow-control state drives both the request line and the in-band stop.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      flow_stop_r <= 1'b0;
    end else if (!mode128) begin
      flow_stop_r <= 1'b0;
    end else if (UART_IN.rx_fill >= hi_level) begin
      flow_stop_r <= 1'b1;
    end else if (UART_IN.rx_fill < lo_level) begin
      flow_stop_r <= 1'b0;
    end
  end

  assign SW_FLOW_STOP = flow_stop_r;

  // Registered copy of the busy level; its falling edge marks the last bit leaving.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tx_busy_d_r <= 1'b0;
    end else begin
      tx_busy_d_r <= UART_IN.tx_busy;
    end
  end

  assign last_bit_out = tx_busy_d_r && !UART_IN.tx_busy;
  assign nine_on = ctrl_r[CTRL_NINE];
  assign count_done = nine_on && (st_r == UFLT_COUNT) && (cnt_r == '0) && !UART_IN.tx_busy;
  assign cnt_load = nine_on && (st_r == UFLT_TX) && last_bit_out;
  assign cnt_step = nine_on && (st_r == UFLT_COUNT) && !UART_IN.tx_busy && (cnt_r != '0)
    && UART_IN.bit_tick;

  // Direction sequencer: high while sending, then counts bit ticks before releasing.
  always_comb begin
    st_nxt = st_r;
    if (!nine_on) begin
      st_nxt = UFLT_IDLE;
    end else begin
      unique case (st_r)
        UFLT_IDLE: begin
          if (UART_IN.tx_busy) begin
            st_nxt = UFLT_TX;
          end
        end
        UFLT_TX: begin
          if (last_bit_out) begin
            st_nxt = UFLT_COUNT;
          end
        end
        UFLT_COUNT: begin
          if (UART_IN.tx_busy) begin
            st_nxt = UFLT_TX;
          end else if (cnt_r == '0) begin
            st_nxt = UFLT_IDLE;
          end
        end
        default: begin
          st_nxt = UFLT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_r <= UFLT_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Turn-around counter: loaded when the last bit has left, then one step per bit period.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt_r <= '0;
    end else if (cnt_load) begin
      cnt_r <= turn_r;
    end else if (cnt_step) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

  // Direction level: raised when sending starts, dropped once the count has run out.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dir_r <= 1'b0;
    end else if (!nine_on) begin
      dir_r <= 1'b0;
    end else if (st_r == UFLT_IDLE && UART_IN.tx_busy) begin
      dir_r <= 1'b1;
    end else if (count_done) begin
      dir_r <= 1'b0;
    end
  end

  // Line selection: the chosen line carries direction; request keeps flow control when terminal-ready is chosen, else terminal-ready stays low.
  always_comb begin
    REQUEST_LINE = flow_stop_r && ctrl_r[CTRL_AUTO_RTS];
    TERMINAL_READY_LINE = 1'b0;
    if (ctrl_r[CTRL_NINE]) begin
      if (ctrl_r[CTRL_DTR_SEL]) begin
        TERMINAL_READY_LINE = dir_r;
      end else begin
        REQUEST_LINE = dir_r;
      end
    end
  end

  assign irq_ev[IRQ_TX] = tx_trig;
  assign irq_ev[IRQ_RX] = rx_trig;
  assign irq_ev[IRQ_FLOW] = flow_stop_r;
  assign irq_ev[IRQ_TURN] = count_done;

  // Sticky status: a read clears only the bits that it returned, so no event is lost.
  always_comb begin
    irq_stat_nxt = irq_stat_r | irq_ev;
    if (addr_hit(rd_en, PADDR, OFS_IRQ_STAT)) begin
      irq_stat_nxt = (irq_stat_r & ~rdata_r[IRQ_W-1:0]) | irq_ev;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  assign IRQ = |(irq_stat_r & irq_mask_r);

  // Read data is taken in the setup cycle and stands through the access phase.
  always_comb begin
    unique case (PADDR)
      OFS_TX_LVL: begin
        rdata_nxt = {24'h0, tx_lvl_r};
      end
      OFS_RX_LVL: begin
        rdata_nxt = {24'h0, rx_lvl_r};
      end
      OFS_FLOW_HI: begin
        rdata_nxt = {24'h0, flow_hi_r};
      end
      OFS_FLOW_LO: begin
        rdata_nxt = {24'h0, flow_lo_r};
      end
      OFS_PRESC: begin
        rdata_nxt = {28'h0, presc_r};
      end
      OFS_TURN: begin
        rdata_nxt = {24'h0, turn_r};
      end
      OFS_CTRL: begin
        rdata_nxt = {24'h0, ctrl_r};
      end
      OFS_STAT: begin
        rdata_nxt = {20'h0, cnt_r, 1'b0, flow_stop_r, dir_r, st_r[0]};
      end
      OFS_IRQ_STAT: begin
        rdata_nxt = {28'h0, irq_stat_r};
      end
      OFS_IRQ_MASK: begin
        rdata_nxt = {28'h0, irq_mask_r};
      end
      default: begin
        rdata_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_r <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign PRDATA = rdata_r;

endmodule // uflt_core
`default_nettype wire

// >>> uflt_shift_mdl.sv
// Shifter model that makes the bit ticks and the busy level.
`default_nettype none
module uflt_shift_mdl #(
  parameter int TICK = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] nbits,
  output logic busy,
  output logic tick
);
  logic [3:0] div_r;
  logic [3:0] left_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= 4'h0;
      tick <= 1'b0;
    end else begin
      tick <= div_r == 4'(TICK - 1);
      div_r <= (div_r == 4'(TICK - 1)) ? 4'h0 : div_r + 4'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) left_r <= 4'h0;
    else if (start) left_r <= nbits;
    else if (tick && left_r != 4'h0) left_r <= left_r - 4'h1;
  end
  assign busy = left_r != 4'h0;
endmodule // uflt_shift_mdl
`default_nettype wire

// >>> uflt_core_chk.sv
// Port-level assertions for the level and turn-around block.
`default_nettype none
module uflt_core_chk
  import uflt_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire uflt_in_s UART_IN,
  input wire logic TX_DMA_REQ,
  input wire logic RX_DMA_REQ,
  input wire logic TERMINAL_READY_LINE,
  input wire logic [3:0] PRESCALE,
  input wire logic IRQ
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic wr;
  assign wr = PSEL && PENABLE && PWRITE;
  presc_hold_a: assert property (!(wr && PADDR == OFS_PRESC) |=> $stable(PRESCALE))
    else $error("prescaler changed without a write");
  presc_load_a: assert property (wr && PADDR == OFS_PRESC |=> PRESCALE == 4'($past(PWDATA)))
    else $error("prescaler not loaded from write data");
  tx_top_a: assert property (UART_IN.tx_fill >= 8'h80 |-> !TX_DMA_REQ)
    else $error("transmit request above top level");
  rx_empty_a: assert property (UART_IN.rx_fill == 8'h00 |-> !RX_DMA_REQ)
    else $error("receive request with empty fifo");
  dir_hold_a: assert property (TERMINAL_READY_LINE && UART_IN.tx_busy |=> TERMINAL_READY_LINE)
    else $error("direction dropped while sending");
  dir_rise_a: assert property ($rose(TERMINAL_READY_LINE) |-> $past(UART_IN.tx_busy))
    else $error("direction raised without sending");
  dir_fall_a: assert property ($fell(TERMINAL_READY_LINE) |-> !$past(UART_IN.tx_busy))
    else $error("direction released while sending");
  turn_wait_a: assert property ($fell(UART_IN.tx_busy) && TERMINAL_READY_LINE
    |-> TERMINAL_READY_LINE [*2])
    else $error("direction released without countdown");
  irq_mask_a: assert property (wr && PADDR == OFS_IRQ_MASK && PWDATA[3:0] == 4'h0 |=> !IRQ)
    else $error("interrupt with all sources masked");
endmodule // uflt_core_chk
bind uflt_core uflt_core_chk chk (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .UART_IN(UART_IN),
  .TX_DMA_REQ(TX_DMA_REQ), .RX_DMA_REQ(RX_DMA_REQ),
  .TERMINAL_READY_LINE(TERMINAL_READY_LINE), .PRESCALE(PRESCALE), .IRQ(IRQ));
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the level and turn-around block.
`default_nettype none
module testbench
  import uflt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, start = 0, err, e;
  logic [7:0] paddr = 0, txf = 0, rxf = 0, code, l, n, ctl;
  logic [31:0] pwdata = 0, prdata, rd, d, seed = 32'h00009732;
  logic pready, pslverr, txd, rxd, rl, tl, swf, irq, busy, tick;
  logic [3:0] presc, nb = 0;
  int error_cnt = 0, n_tests = 0, c;
  always #50 mclk = ~mclk;
  uflt_core dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .UART_IN({txf, rxf, busy, tick}), .TX_DMA_REQ(txd), .RX_DMA_REQ(rxd), .REQUEST_LINE(rl),
    .TERMINAL_READY_LINE(tl), .SW_FLOW_STOP(swf), .PRESCALE(presc), .IRQ(irq));
  uflt_shift_mdl #(.TICK(4)) shifter (.clk(mclk), .rst(rst), .start(start), .nbits(nb),
    .busy(busy), .tick(tick));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] lvl(input logic [7:0] k);
    return k == 8'h00 ? 8'h01 : (k > 8'h80 ? 8'h80 : k);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    pen <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic flow(input logic [7:0] f, input logic x);
    rxf <= f;
    repeat (3) @(posedge mclk);
    chk({30'h0, rl, swf}, {30'h0, x, x});
  endtask
  task automatic results();
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a <= 40; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, {31'h0, a == 40});
    end
    for (int a = 0; a <= 20; a += 4) begin
      d = rnd();
      apb(1'b1, 8'(a), d);
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, {24'h0, d[7:0] & (a == 16 ? 8'h0f : 8'hff)});
      if (a == 16) begin
        chk({28'h0, presc}, {28'h0, d[3:0]});
      end
    end
    apb(1'b1, OFS_CTRL, 32'h80);
    for (int i = 0; i < 8; i++) begin
      code = i == 0 ? 8'h00 : (i == 1 ? 8'h01 : (i == 2 ? 8'h80 : (i == 3 ? 8'hff : 8'(rnd()))));
      l = lvl(code);
      apb(1'b1, OFS_TX_LVL, {24'h0, code});
      apb(1'b1, OFS_RX_LVL, {24'h0, code});
      txf <= l - 8'h01;
      rxf <= l;
      @(posedge mclk);
      chk({30'h0, txd, rxd}, 32'h3);
      txf <= l;
      rxf <= l - 8'h01;
      @(posedge mclk);
      chk({30'h0, txd, rxd}, 32'h0);
    end
    apb(1'b1, OFS_CTRL, 32'h0);
    txf <= 8'h00;
    rxf <= 8'hff;
    @(posedge mclk);
    chk({30'h0, txd, rxd}, 32'h0);
    apb(1'b1, OFS_FLOW_HI, 32'h40);
    apb(1'b1, OFS_FLOW_LO, 32'h10);
    apb(1'b1, OFS_CTRL, 32'hc0);
    flow(8'h3f, 1'b0);
    flow(8'h40, 1'b1);
    flow(8'h10, 1'b1);
    flow(8'h0f, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'h8);
    for (int i = 0; i < 3; i++) begin
      ctl = i == 0 ? 8'h81 : (i == 1 ? 8'h89 : 8'h80);
      e = ctl[0];
      n = 8'(rnd() % 4 + 1);
      apb(1'b1, OFS_TURN, {24'h0, n});
      apb(1'b1, OFS_CTRL, {24'h0, ctl});
      nb <= 4'(rnd() % 4 + 3);
      start <= 1'b1;
      @(posedge mclk);
      start <= 1'b0;
      repeat (2) @(posedge mclk);
      chk({30'h0, rl, tl}, {30'h0, e & !ctl[3], e & ctl[3]});
      while (busy) @(posedge mclk);
      c = 0;
      while ((rl | tl) === 1'b1 && c < 200) begin
        @(posedge mclk);
        c++;
      end
      chk(32'(e ? (c >= (n - 1) * 4 && c <= (n + 1) * 4 + 3) : c == 0), 32'h1);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, {31'h0, e});
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd & 32'h8, e ? 32'h8 : 32'h0);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
    end
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    results();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    results();
  end
endmodule // testbench
`default_nettype wire
